// ===== rtl/cond_eval.sv
// Jump condition evaluation for the index, switch, wrap and condition-field branches
`timescale 1ns/10ps
module cond_eval (
  input scx_pkg::op_e op_i,
  input wire logic [5:0] cond_i,
  input wire logic [15:0] acc_i,
  input wire logic [15:0] idx_i,
  input wire logic switch_i,
  input wire logic wrap_i,
  output logic take_o,
  output logic wrap_clr_o
);

  logic idx_zero;
  logic acc_neg;

  assign idx_zero = idx_i == 16'h0000;
  assign acc_neg = acc_i[15];

  always_comb begin
    take_o = 1'b0;
    wrap_clr_o = 1'b0;
    unique case (op_i)
      scx_pkg::branch_index_zero: take_o = idx_zero;
      scx_pkg::branch_index_nonzero: take_o = !idx_zero;
      scx_pkg::branch_switch_on: take_o = switch_i;
      scx_pkg::branch_switch_off: take_o = !switch_i;
      scx_pkg::branch_wrap_set: begin
        take_o = wrap_i;
        wrap_clr_o = wrap_i;
      end
      scx_pkg::branch_wrap_clear: take_o = !wrap_i;
      scx_pkg::branch_on_condition_field: begin
        if (cond_i[scx_pkg::T_GROUP]) begin
          // Unselected terms pass, so an empty selection always jumps
          take_o = (!cond_i[scx_pkg::T_IDX] || !idx_zero)
            && (!cond_i[scx_pkg::T_ACC] || !acc_neg);
        end else begin
          take_o = (cond_i[scx_pkg::T_IDX] && idx_zero)
            || (cond_i[scx_pkg::T_SW] && !switch_i)
            || (cond_i[scx_pkg::T_WRAP] && wrap_i)
            || (cond_i[scx_pkg::T_ACC] && acc_neg);
          wrap_clr_o = cond_i[scx_pkg::T_WRAP] && wrap_i;
        end
      end
      // Stack codes never reach the branch path
      default: take_o = 1'b0;
    endcase
  end

endmodule

// ===== rtl/scx_pkg.sv
// Shared constants, opcodes and decode helpers for the stack and branch execution unit
package scx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_TGT = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_IDX = 8'h0c;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_FLAG = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_SEA = 8'h1c;

  // Field positions
  localparam int OP_LSB = 0;
  localparam int OP_MSB = 3;
  localparam int COND_LSB = 7;
  localparam int COND_MSB = 12;
  localparam int T_ACC = 0;
  localparam int T_WRAP = 2;
  localparam int T_SW = 3;
  localparam int T_IDX = 4;
  localparam int T_GROUP = 5;
  localparam int FLAG_WRAP_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;
  localparam int STAT_SW_BIT = 2;

  // Reset values and program counter steps
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_BIT = 1'b0;
  localparam logic [15:0] STACK_LEN = 16'h0002;
  localparam logic [15:0] JUMP_LEN = 16'h0001;

  typedef enum logic [3:0] {
    stack_bitwise_conj, stack_incl_disj, stack_excl_disj, stack_swap_acc,
    stack_load_acc, stack_load_index, stack_store_acc, stack_store_index,
    branch_index_zero, branch_index_nonzero, branch_switch_on, branch_switch_off,
    branch_wrap_set, branch_wrap_clear, branch_on_condition_field
  } op_e;

  typedef enum logic [2:0] {st_idle, st_ptr_rd, st_elem_rd, st_elem_wr, st_branch} state_e;

  function automatic logic op_legal(logic [3:0] code);
    return code != 4'hf;
  endfunction

  function automatic logic is_branch(op_e op);
    return op >= branch_index_zero;
  endfunction

  // Stores skip the element read and go straight to the write
  function automatic logic is_store(op_e op);
    return op == stack_store_acc || op == stack_store_index;
  endfunction

endpackage

// ===== rtl/stack_alu.sv
// Combinational result logic for the stack logical and transfer operations
`timescale 1ns/10ps
module stack_alu (
  input scx_pkg::op_e op_i,
  input wire logic [15:0] acc_i,
  input wire logic [15:0] idx_i,
  input wire logic [15:0] elem_i,
  output logic [15:0] acc_o,
  output logic [15:0] idx_o,
  output logic [15:0] wdata_o
);

  always_comb begin
    acc_o = acc_i;
    idx_o = idx_i;
    wdata_o = acc_i;
    unique case (op_i)
      scx_pkg::stack_bitwise_conj: acc_o = acc_i & elem_i;
      scx_pkg::stack_incl_disj: acc_o = acc_i | elem_i;
      scx_pkg::stack_excl_disj: acc_o = acc_i ^ elem_i;
      scx_pkg::stack_swap_acc: acc_o = elem_i;
      scx_pkg::stack_load_acc: acc_o = elem_i;
      scx_pkg::stack_load_index: idx_o = elem_i;
      scx_pkg::stack_store_acc: wdata_o = acc_i;
      scx_pkg::stack_store_index: wdata_o = idx_i;
      // Branch codes never reach the element path
      default: acc_o = acc_i;
    endcase
  end

endmodule

// ===== rtl/stack_branch_exec.sv
// Stack operation and conditional branch execution unit with a Wishbone register slave
// Function
// - The conjunction operation Stack_bitwise_conj the stack element into A.
// - The inclusive disjunction operation ORs the stack element into A.
// - The exclusive disjunction operation Stack_excl_disj the stack element into A.
// - The swap operation writes old A to the element and loads the old element into A.
// - The load-accumulator operation copies the element into A, memory untouched.
// - The load-index operation copies the element into X, memory untouched.
// - The store-accumulator operation writes A to the element, A unchanged.
// - The store-index operation writes X to the element, X unchanged.
// - Branch on index zero jumps only when X is all zero.
// - Branch on index nonzero jumps only when X is nonzero.
// - Branch on switch on jumps only while the operator switch is asserted.
// - Branch on switch off jumps only while the operator switch is deasserted.
// - Branch on wrap set jumps when the wrap flag is one and clears it.
// - Branch on wrap clear jumps only when the wrap flag is zero and keeps it.
// - The condition-field jump decodes bits 12..7 into an AND group or an OR group.
// - The element address is the pointer word read from the address in word two.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module stack_branch_exec (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic switch_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic busy_o
);

  typedef struct packed {
    scx_pkg::state_e st;
    scx_pkg::op_e op;
    logic [15:0] ir;
    logic [15:0] tgt;
    logic [15:0] a;
    logic [15:0] x;
    logic [15:0] p;
    logic [15:0] stack_elem_addr;
    logic [15:0] elem;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] rdat;
    logic wrap;
    logic taken;
    logic mem_req;
    logic mem_we;
    logic ack;
  } state_s;

  state_s q;
  state_s next_q;

  logic [15:0] alu_acc;
  logic [15:0] alu_idx;
  logic [15:0] alu_wdata;
  logic br_take;
  logic br_wrap_clr;
  logic bus_new;
  logic bus_wr;
  logic idle;
  logic mem_done;

  function automatic logic [15:0] merge16(logic [15:0] old, logic [15:0] d, logic [1:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction

  stack_alu stack_alu_i (
    .op_i(q.op),
    .acc_i(q.a),
    .idx_i(q.x),
    .elem_i(mem_rdata_i),
    .acc_o(alu_acc),
    .idx_o(alu_idx),
    .wdata_o(alu_wdata)
  );

  cond_eval cond_eval_i (
    .op_i(q.op),
    .cond_i(q.ir[scx_pkg::COND_MSB:scx_pkg::COND_LSB]),
    .acc_i(q.a),
    .idx_i(q.x),
    .switch_i(switch_i),
    .wrap_i(q.wrap),
    .take_o(br_take),
    .wrap_clr_o(br_wrap_clr)
  );

  // One new bus request per cycle pair: ack follows one cycle after the strobe
  assign bus_new = wb_cyc_i && wb_stb_i && !q.ack;
  assign bus_wr = bus_new && wb_we_i;
  assign idle = q.st == scx_pkg::st_idle;
  assign mem_done = q.mem_req && mem_ack_i;

  always_comb begin
    next_q = q;
    next_q.ack = bus_new;
    // Register reads
    if (bus_new) begin
      unique case (wb_adr_i)
        scx_pkg::OFF_CMD: next_q.rdat = q.ir;
        scx_pkg::OFF_TGT: next_q.rdat = q.tgt;
        scx_pkg::OFF_ACC: next_q.rdat = q.a;
        scx_pkg::OFF_IDX: next_q.rdat = q.x;
        scx_pkg::OFF_PC: next_q.rdat = q.p;
        scx_pkg::OFF_FLAG: next_q.rdat = {15'h0000, q.wrap};
        scx_pkg::OFF_STAT: next_q.rdat = {13'h0000, switch_i, q.taken, !idle};
        scx_pkg::OFF_SEA: next_q.rdat = q.stack_elem_addr;
        default: next_q.rdat = scx_pkg::RST_WORD;
      endcase
    end
    // Writes are refused while an operation runs so the datapath sees stable operands
    if (bus_wr && idle) begin
      unique case (wb_adr_i)
        scx_pkg::OFF_CMD: begin
          next_q.ir = merge16(q.ir, wb_dat_i[15:0], wb_sel_i[1:0]);
          if (wb_sel_i[0] && scx_pkg::op_legal(wb_dat_i[scx_pkg::OP_MSB:scx_pkg::OP_LSB])) begin
            next_q.op = scx_pkg::op_e'(wb_dat_i[scx_pkg::OP_MSB:scx_pkg::OP_LSB]);
            next_q.taken = 1'b0;
            if (scx_pkg::is_branch(next_q.op)) begin
              next_q.st = scx_pkg::st_branch;
            end else begin
              next_q.st = scx_pkg::st_ptr_rd;
              next_q.mem_req = 1'b1;
              next_q.mem_we = 1'b0;
              next_q.mem_addr = q.tgt;
            end
          end
        end
        scx_pkg::OFF_TGT: next_q.tgt = merge16(q.tgt, wb_dat_i[15:0], wb_sel_i[1:0]);
        scx_pkg::OFF_ACC: next_q.a = merge16(q.a, wb_dat_i[15:0], wb_sel_i[1:0]);
        scx_pkg::OFF_IDX: next_q.x = merge16(q.x, wb_dat_i[15:0], wb_sel_i[1:0]);
        scx_pkg::OFF_PC: next_q.p = merge16(q.p, wb_dat_i[15:0], wb_sel_i[1:0]);
        scx_pkg::OFF_FLAG: begin
          if (wb_sel_i[0]) begin
            next_q.wrap = wb_dat_i[scx_pkg::FLAG_WRAP_BIT];
          end
        end
        default: next_q.rdat = next_q.rdat;
      endcase
    end
    unique case (q.st)
      scx_pkg::st_idle: begin
        next_q.mem_req = next_q.mem_req && !idle ? 1'b1 : next_q.mem_req;
      end
      scx_pkg::st_ptr_rd: begin
        if (mem_done) begin
          next_q.mem_req = 1'b0;
          next_q.stack_elem_addr = mem_rdata_i;
          next_q.mem_addr = mem_rdata_i;
          if (scx_pkg::is_store(q.op)) begin
            next_q.st = scx_pkg::st_elem_wr;
            next_q.mem_we = 1'b1;
            next_q.mem_wdata = alu_wdata;
          end else begin
            next_q.st = scx_pkg::st_elem_rd;
          end
        end
      end
      scx_pkg::st_elem_rd: begin
        if (!q.mem_req) begin
          next_q.mem_req = 1'b1;
        end else if (mem_ack_i) begin
          next_q.mem_req = 1'b0;
          if (q.op == scx_pkg::stack_swap_acc) begin
            // A is only replaced once the write has landed, so the exchange commits as one
            next_q.elem = mem_rdata_i;
            next_q.mem_we = 1'b1;
            next_q.mem_wdata = q.a;
            next_q.st = scx_pkg::st_elem_wr;
          end else begin
            next_q.a = alu_acc;
            next_q.x = alu_idx;
            next_q.p = q.p + scx_pkg::STACK_LEN;
            next_q.st = scx_pkg::st_idle;
          end
        end
      end
      scx_pkg::st_elem_wr: begin
        if (!q.mem_req) begin
          next_q.mem_req = 1'b1;
        end else if (mem_ack_i) begin
          next_q.mem_req = 1'b0;
          next_q.mem_we = 1'b0;
          if (q.op == scx_pkg::stack_swap_acc) begin
            next_q.a = q.elem;
          end
          next_q.p = q.p + scx_pkg::STACK_LEN;
          next_q.st = scx_pkg::st_idle;
        end
      end
      scx_pkg::st_branch: begin
        next_q.taken = br_take;
        next_q.p = br_take ? q.tgt : q.p + scx_pkg::JUMP_LEN;
        if (br_wrap_clr) begin
          next_q.wrap = 1'b0;
        end
        next_q.st = scx_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: scx_pkg::st_idle, op: scx_pkg::stack_bitwise_conj,
        ir: scx_pkg::RST_WORD, tgt: scx_pkg::RST_WORD, a: scx_pkg::RST_WORD,
        x: scx_pkg::RST_WORD, p: scx_pkg::RST_WORD, stack_elem_addr: scx_pkg::RST_WORD,
        elem: scx_pkg::RST_WORD, mem_addr: scx_pkg::RST_WORD,
        mem_wdata: scx_pkg::RST_WORD, rdat: scx_pkg::RST_WORD,
        wrap: scx_pkg::RST_BIT, taken: scx_pkg::RST_BIT, mem_req: scx_pkg::RST_BIT,
        mem_we: scx_pkg::RST_BIT, ack: scx_pkg::RST_BIT};
    end else begin
      q <= next_q;
    end
  end

  assign wb_dat_o = {16'h0000, q.rdat};
  assign wb_ack_o = q.ack;
  assign mem_req_o = q.mem_req;
  assign mem_we_o = q.mem_we;
  assign mem_addr_o = q.mem_addr;
  assign mem_wdata_o = q.mem_wdata;
  assign busy_o = !idle;

  // Checks
  logic rd_done;
  logic br_fire;
  logic [5:0] tc;

  assign rd_done = q.st == scx_pkg::st_elem_rd && mem_done;
  assign br_fire = q.st == scx_pkg::st_branch;
  assign tc = q.ir[scx_pkg::COND_MSB:scx_pkg::COND_LSB];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property acc_op_p(scx_pkg::op_e o, logic [15:0] r);
    rd_done && q.op == o |=> q.a == $past(r);
  endproperty

  property jump_p(scx_pkg::op_e o, logic c);
    br_fire && q.op == o |=> q.p == ($past(c) ? $past(q.tgt) : $past(q.p) + scx_pkg::JUMP_LEN);
  endproperty

  conj_result_a: assert property (acc_op_p(scx_pkg::stack_bitwise_conj, q.a & mem_rdata_i))
    else $error("conjunction result wrong");
  incl_result_a: assert property (acc_op_p(scx_pkg::stack_incl_disj, q.a | mem_rdata_i))
    else $error("inclusive result wrong");
  excl_result_a: assert property (acc_op_p(scx_pkg::stack_excl_disj, q.a ^ mem_rdata_i))
    else $error("exclusive result wrong");
  swap_exchange_a: assert property (rd_done && q.op == scx_pkg::stack_swap_acc
    |=> q.mem_we && q.mem_wdata == $past(q.a) && q.a == $past(q.a)
    && q.elem == $past(mem_rdata_i) && q.st == scx_pkg::st_elem_wr)
    else $error("swap did not exchange");
  swap_commit_a: assert property (q.st == scx_pkg::st_elem_wr && mem_done
    && q.op == scx_pkg::stack_swap_acc |=> q.a == $past(q.elem) && !q.mem_we)
    else $error("swap commit wrong");
  load_acc_a: assert property (acc_op_p(scx_pkg::stack_load_acc, mem_rdata_i))
    else $error("accumulator load wrong");
  load_idx_a: assert property (rd_done && q.op == scx_pkg::stack_load_index
    |=> q.x == $past(mem_rdata_i) && q.a == $past(q.a) && !q.mem_we)
    else $error("index load wrong");
  store_acc_a: assert property (q.st == scx_pkg::st_elem_wr && q.mem_req
    && q.op == scx_pkg::stack_store_acc |-> mem_we_o && mem_wdata_o == q.a)
    else $error("accumulator store wrong");
  store_idx_a: assert property (q.st == scx_pkg::st_elem_wr && q.mem_req
    && q.op == scx_pkg::stack_store_index |-> mem_we_o && mem_wdata_o == q.x)
    else $error("index store wrong");
  idx_zero_a: assert property (jump_p(scx_pkg::branch_index_zero, q.x == 16'h0000))
    else $error("index zero jump wrong");
  idx_nonzero_a: assert property (jump_p(scx_pkg::branch_index_nonzero, q.x != 16'h0000))
    else $error("index nonzero jump wrong");
  sw_on_a: assert property (jump_p(scx_pkg::branch_switch_on, switch_i))
    else $error("switch on jump wrong");
  sw_off_a: assert property (jump_p(scx_pkg::branch_switch_off, !switch_i))
    else $error("switch off jump wrong");
  wrap_set_a: assert property (br_fire && q.op == scx_pkg::branch_wrap_set
    |=> !q.wrap && q.p == ($past(q.wrap) ? $past(q.tgt) : $past(q.p) + scx_pkg::JUMP_LEN))
    else $error("wrap set jump wrong");
  wrap_clear_a: assert property (br_fire && q.op == scx_pkg::branch_wrap_clear
    |=> q.wrap == $past(q.wrap) && q.taken == !$past(q.wrap))
    else $error("wrap clear jump wrong");
  and_group_a: assert property (br_fire && q.op == scx_pkg::branch_on_condition_field
    && tc[5] |=> q.taken == $past((!tc[4] || q.x != 16'h0000) && (!tc[0] || !q.a[15])))
    else $error("and group wrong");
  or_group_a: assert property (br_fire && q.op == scx_pkg::branch_on_condition_field
    && !tc[5] |=> q.taken == $past((tc[4] && q.x == 16'h0000) || (tc[3] && !switch_i)
    || (tc[2] && q.wrap) || (tc[0] && q.a[15])) && q.wrap == $past(q.wrap && !tc[2]))
    else $error("or group wrong");
  elem_addr_a: assert property (q.st == scx_pkg::st_ptr_rd && mem_done
    |=> q.stack_elem_addr == $past(mem_rdata_i) ##1 mem_addr_o == q.stack_elem_addr)
    else $error("element address wrong");
  next_seq_a: assert property (br_fire |=> q.st == scx_pkg::st_idle
    && q.taken == $past(br_take)
    && q.p == ($past(br_take) ? $past(q.tgt) : $past(q.p) + scx_pkg::JUMP_LEN))
    else $error("program counter step wrong");

  // Memory may stall for any time, so the request must not drift while it waits
  mem_hold_a: assert property (mem_req_o && !mem_ack_i
    |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request moved before ack");
  store_keeps_acc_a: assert property (q.st == scx_pkg::st_elem_wr && mem_done
    && q.op == scx_pkg::stack_store_acc |=> q.a == $past(q.a))
    else $error("accumulator store changed A");
  store_keeps_idx_a: assert property (q.st == scx_pkg::st_elem_wr && mem_done
    && q.op == scx_pkg::stack_store_index |=> q.x == $past(q.x))
    else $error("index store changed X");
  load_no_write_a: assert property (q.st == scx_pkg::st_elem_rd
    && q.mem_req |-> !mem_we_o)
    else $error("load wrote memory");
  // Pointer address must not move under a running operation
  busy_refuse_a: assert property (!idle && bus_wr && wb_adr_i == scx_pkg::OFF_TGT
    |=> q.tgt == $past(q.tgt))
    else $error("write accepted while busy");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  swap_seen_c: cover property (q.st == scx_pkg::st_elem_wr && mem_done
    && q.op == scx_pkg::stack_swap_acc);
  or_taken_c: cover property (br_fire && q.op == scx_pkg::branch_on_condition_field
    && !tc[5] && br_take);
  store_seen_c: cover property (q.st == scx_pkg::st_elem_wr && mem_done
    && q.op == scx_pkg::stack_store_index);
  wrap_taken_c: cover property (br_fire && q.op == scx_pkg::branch_wrap_set && br_take);
  stall_seen_c: cover property (mem_req_o && !mem_ack_i ##1 mem_req_o && !mem_ack_i);

endmodule

// ===== testbench/mem_model.sv
// Behavioural word memory on the far side of the execution unit's memory link
`timescale 1ns/10ps
module mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] wait_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_ack_o
);
  logic [15:0] mem [256];
  logic [1:0] cnt;
  // Read bus flips every cycle outside an answer, so stale data never looks valid
  always @(posedge clk_i) begin
    mem_rdata_o <= ~mem_rdata_o;
    mem_ack_o <= 1'b0;
    if (rst_i) begin
      cnt <= 2'h0;
      mem_rdata_o <= 16'h5a5a;
    end else if (mem_req_i && !mem_ack_o) begin
      if (cnt == wait_i) begin
        cnt <= 2'h0;
        mem_ack_o <= 1'b1;
        if (mem_we_i) begin
          mem[mem_addr_i[7:0]] <= mem_wdata_i;
        end else begin
          mem_rdata_o <= mem[mem_addr_i[7:0]];
        end
      end else begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule

// ===== testbench/stack_op_and_cond_branch_exec_tb.sv
// Self-checking bench for the stack operation and conditional branch unit
`timescale 1ns/10ps
module stack_op_and_cond_branch_exec_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic switch_i = 1'b0;
  logic [1:0] mem_wait = 2'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, busy_o;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [15:0] exp_p = 16'h0000;
  int err_count = 0;
  int num_checks = 0;

  always #12.5 clk_i = ~clk_i;

  stack_branch_exec stack_branch_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .switch_i(switch_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .busy_o(busy_o));

  mem_model mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .wait_i(mem_wait),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));

  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [15:0] dat,
                          output logic [31:0] rd);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    chk("wb ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
    logic [31:0] d;
    wb_cycle(1'b1, adr, dat, d);
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [15:0] exp, input string what);
    logic [31:0] d;
    wb_cycle(1'b0, adr, 16'h0, d);
    chk(what, d, {16'h0, exp});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("busy", {31'h0, busy_o}, 32'h0);
  endtask

  // Pointer word at 0x10 names the element at 0x40
  task automatic do_stack(input scx_pkg::op_e op, input logic [15:0] a, x, e, ea, ex, em);
    mem_model_i.mem[8'h10] = 16'h0040;
    mem_model_i.mem[8'h40] = e;
    wr(scx_pkg::OFF_ACC, a);
    wr(scx_pkg::OFF_IDX, x);
    wr(scx_pkg::OFF_TGT, 16'h0010);
    wr(scx_pkg::OFF_CMD, 16'(op));
    // Taken while the operation still runs, so it must be ignored
    wr(scx_pkg::OFF_IDX, 16'hdead);
    wait_idle();
    exp_p = exp_p + scx_pkg::STACK_LEN;
    rdchk(scx_pkg::OFF_PC, exp_p, "P after stack op");
    rdchk(scx_pkg::OFF_ACC, ea, "A");
    rdchk(scx_pkg::OFF_IDX, ex, "X");
    rdchk(8'h1c, 16'h0040, "element address");
    chk("element", {16'h0, mem_model_i.mem[8'h40]}, {16'h0, em});
  endtask

  task automatic do_branch(input scx_pkg::op_e op, input logic [5:0] cond, input logic take);
    wr(scx_pkg::OFF_TGT, 16'h0123);
    wr(scx_pkg::OFF_CMD, {3'h0, cond, 3'h0, 4'(op)});
    wait_idle();
    exp_p = take ? 16'h0123 : exp_p + scx_pkg::JUMP_LEN;
    rdchk(scx_pkg::OFF_PC, exp_p, "P");
    rdchk(scx_pkg::OFF_STAT, {13'h0, switch_i, take, 1'b0}, "taken");
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rdchk(8'(i * 4), 16'h0, "reset value");
    end
    // Illegal opcode is stored only; nothing may start
    wr(scx_pkg::OFF_CMD, 16'h000f);
    rdchk(scx_pkg::OFF_STAT, 16'h0, "stat idle");
    rdchk(scx_pkg::OFF_CMD, 16'h000f, "command stored");
    rdchk(scx_pkg::OFF_PC, 16'h0, "P idle");
    wr(8'h20, 16'hffff);
    rdchk(8'h20, 16'h0, "unmapped");
  endtask

  task automatic t_logic();
    do_stack(scx_pkg::stack_bitwise_conj, 16'hf0f0, 16'h1234, 16'hff00, 16'hf000, 16'h1234,
             16'hff00);
    do_stack(scx_pkg::stack_incl_disj, 16'hf0f0, 16'h1234, 16'hff00, 16'hfff0, 16'h1234,
             16'hff00);
    do_stack(scx_pkg::stack_excl_disj, 16'hf0f0, 16'h1234, 16'hff00, 16'h0ff0, 16'h1234,
             16'hff00);
  endtask

  // Slow memory: three wait cycles on every access
  task automatic t_transfer();
    mem_wait <= 2'h3;
    do_stack(scx_pkg::stack_swap_acc, 16'h1111, 16'h2222, 16'h3333, 16'h3333, 16'h2222, 16'h1111);
    do_stack(scx_pkg::stack_load_acc, 16'h1111, 16'h2222, 16'h3333, 16'h3333, 16'h2222, 16'h3333);
    do_stack(scx_pkg::stack_load_index, 16'h1111, 16'h2222, 16'h3333, 16'h1111, 16'h3333,
             16'h3333);
    do_stack(scx_pkg::stack_store_acc, 16'h1111, 16'h2222, 16'h3333, 16'h1111, 16'h2222,
             16'h1111);
    do_stack(scx_pkg::stack_store_index, 16'h1111, 16'h2222, 16'h3333, 16'h1111, 16'h2222,
             16'h2222);
    mem_wait <= 2'h0;
  endtask

  task automatic t_index();
    wr(scx_pkg::OFF_IDX, 16'h0000);
    do_branch(scx_pkg::branch_index_zero, 6'h00, 1'b1);
    do_branch(scx_pkg::branch_index_nonzero, 6'h00, 1'b0);
    wr(scx_pkg::OFF_IDX, 16'h8000);
    do_branch(scx_pkg::branch_index_zero, 6'h00, 1'b0);
    do_branch(scx_pkg::branch_index_nonzero, 6'h00, 1'b1);
  endtask

  task automatic t_switch();
    switch_i <= 1'b1;
    @(posedge clk_i);
    do_branch(scx_pkg::branch_switch_on, 6'h00, 1'b1);
    do_branch(scx_pkg::branch_switch_off, 6'h00, 1'b0);
    switch_i <= 1'b0;
    @(posedge clk_i);
    do_branch(scx_pkg::branch_switch_on, 6'h00, 1'b0);
    do_branch(scx_pkg::branch_switch_off, 6'h00, 1'b1);
  endtask

  task automatic t_wrap();
    wr(scx_pkg::OFF_FLAG, 16'h0001);
    do_branch(scx_pkg::branch_wrap_clear, 6'h00, 1'b0);
    rdchk(scx_pkg::OFF_FLAG, 16'h0001, "wrap kept");
    do_branch(scx_pkg::branch_wrap_set, 6'h00, 1'b1);
    rdchk(scx_pkg::OFF_FLAG, 16'h0000, "wrap cleared");
    do_branch(scx_pkg::branch_wrap_set, 6'h00, 1'b0);
    do_branch(scx_pkg::branch_wrap_clear, 6'h00, 1'b1);
  endtask

  task automatic t_field();
    wr(scx_pkg::OFF_IDX, 16'h0005);
    wr(scx_pkg::OFF_ACC, 16'h0001);
    do_branch(scx_pkg::branch_on_condition_field, 6'h31, 1'b1);
    wr(scx_pkg::OFF_ACC, 16'h8000);
    do_branch(scx_pkg::branch_on_condition_field, 6'h31, 1'b0);
    do_branch(scx_pkg::branch_on_condition_field, 6'h01, 1'b1);
    do_branch(scx_pkg::branch_on_condition_field, 6'h10, 1'b0);
    do_branch(scx_pkg::branch_on_condition_field, 6'h08, 1'b1);
    wr(scx_pkg::OFF_FLAG, 16'h0001);
    do_branch(scx_pkg::branch_on_condition_field, 6'h04, 1'b1);
    rdchk(scx_pkg::OFF_FLAG, 16'h0000, "wrap cleared");
    wr(scx_pkg::OFF_ACC, 16'h0001);
    do_branch(scx_pkg::branch_on_condition_field, 6'h01, 1'b0);
    wr(scx_pkg::OFF_IDX, 16'h0000);
    do_branch(scx_pkg::branch_on_condition_field, 6'h30, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_logic();
    t_transfer();
    t_index();
    t_switch();
    t_wrap();
    t_field();
    results();
  end

  // Whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule
